// File: rtl/pao_pkg.sv
package pao_pkg;

  // ==========================================================================
  // Bus map
  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_PORTB    = 32'h0000_0004;
  localparam logic [31:0] ADDR_PORTC    = 32'h0000_0008;
  localparam logic [31:0] ADDR_PORTD    = 32'h0000_000c;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0010;
  localparam int          ADDR_MSB      = 4;
  localparam int          ADDR_LSB      = 2;

  // ==========================================================================
  // Port register fields: [7:0] data, [15:8] direction
  localparam int DATA_LSB = 0;
  localparam int DIR_LSB  = 8;
  localparam logic [7:0] PORT_RST = 8'h00;

  // ==========================================================================
  // Control register fields
  localparam int CTL_EXT_MEM    = 0;
  localparam int CTL_REL_LSB    = 1;
  localparam int CTL_REL_W      = 3;
  localparam int CTL_SER_ON     = 4;
  localparam int CTL_SER_MASTER = 5;
  localparam int CTL_PULL_OFF   = 6;
  localparam int CTL_T0_EN      = 7;
  localparam int CTL_T1A_EN     = 8;
  localparam int CTL_USART_SYNC = 9;
  localparam int CTL_TX_EN      = 10;
  localparam int CTL_IRQ0_EN    = 11;
  localparam int CTL_IRQ1_EN    = 12;
  localparam int CTL_W          = 13;
  localparam logic [CTL_W-1:0] CTL_RST = 13'h0000;

  // ==========================================================================
  // Pin positions
  localparam int PB_T0   = 0;
  localparam int PB_T1   = 1;
  localparam int PB_CPOS = 2;
  localparam int PB_CNEG = 3;
  localparam int PB_SEL  = 4;
  localparam int PB_MOSI = 5;
  localparam int PB_MISO = 6;
  localparam int PB_SCK  = 7;
  localparam int PD_TX   = 1;
  localparam int PD_IRQ0 = 2;
  localparam int PD_IRQ1 = 3;
  localparam int PD_XCK  = 4;
  localparam int PD_T1A  = 5;
  localparam int PD_WR   = 6;
  localparam int PD_RD   = 7;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// File: rtl/pao_pin.sv
`timescale 1ns/1ps
`default_nettype none

// One pin: override enables replace port-register drive
module pao_pin (
  input  wire logic port_val_i,
  input  wire logic port_dir_i,
  input  wire logic pull_off_i,
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic direction_override_en,
  input  wire logic direction_override_val,
  input  wire logic pin_value_override_en,
  input  wire logic pin_value_override_val,
  output      logic out_o,
  output      logic oe_o,
  output      logic pull_o
);
  logic dir;
  // [RULE19] Plain port path
  assign dir    = direction_override_en ? direction_override_val : port_dir_i;
  assign oe_o   = dir;
  assign out_o  = pin_value_override_en ? pin_value_override_val
                                        : port_val_i;
  assign pull_o = pullup_override_en ? pullup_override_val
                                     : (port_val_i & ~port_dir_i & ~pull_off_i);
endmodule

`default_nettype wire

// File: rtl/pao_bank.sv
`timescale 1ns/1ps
`default_nettype none

// Eight pins of one port
module pao_bank #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] val_i,
  input  wire logic [W-1:0] dir_i,
  input  wire logic         pull_off_i,
  input  wire logic [W-1:0] pullup_override_en_i,
  input  wire logic [W-1:0] puov_i,
  input  wire logic [W-1:0] direction_override_en_i,
  input  wire logic [W-1:0] direction_override_val_i,
  input  wire logic [W-1:0] pin_value_override_en_i,
  input  wire logic [W-1:0] pin_value_override_val_i,
  output      logic [W-1:0] out_o,
  output      logic [W-1:0] oe_o,
  output      logic [W-1:0] pull_o
);
  for (genvar g = 0; g < W; g++) begin : g_pin
    pao_pin u_pin (
      .port_val_i             (val_i[g]),
      .port_dir_i             (dir_i[g]),
      .pull_off_i             (pull_off_i),
      .pullup_override_en     (pullup_override_en_i[g]),
      .pullup_override_val    (puov_i[g]),
      .direction_override_en  (direction_override_en_i[g]),
      .direction_override_val (direction_override_val_i[g]),
      .pin_value_override_en  (pin_value_override_en_i[g]),
      .pin_value_override_val (pin_value_override_val_i[g]),
      .out_o                  (out_o[g]),
      .oe_o                   (oe_o[g]),
      .pull_o                 (pull_o[g])
    );
  end
endmodule

`default_nettype wire

// File: rtl/pao_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RULE1] Timer0 compare drives B0 only if output
// [RULE2] Timer0 waveform shares the B0 override
// [RULE3] Software leaves B3, B2 input, no pull-up
// [RULE4] MISO: master input, slave output
// [RULE5] MOSI: master output, slave input
// [RULE6] C7..C0 carry address bits 15..8
// [RULE7] C7..C2 freed by release field thresholds
// [RULE8] C1, C0 freed together only at seven
// [RULE9] D7 carries read strobe under external memory
// [RULE10] D6 carries write strobe under external memory
// [RULE11] Timer1 A drives D5 only if output
// [RULE12] D4 direction picks clock out or in
// [RULE13] D4 clock only in synchronous mode
// [RULE14] D2 aux clock direction from its bit
// [RULE15] Transmitter forces D1 output with data
// [RULE16] D3, D2 feed external interrupts
// [RULE17] Slave active only while select low
// [RULE18] Slave forces clock pin input
// [RULE19] Inactive overrides follow port registers
module pao_top (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output      logic [31:0] hrdata_o,
  output      logic        hreadyout_o,
  output      logic        hresp_o,
  // Pins
  input  wire logic [7:0]  pb_in_i,
  input  wire logic [7:0]  pc_in_i,
  input  wire logic [7:0]  pd_in_i,
  output      logic [7:0]  pb_out_o,
  output      logic [7:0]  pb_oe_o,
  output      logic [7:0]  pb_pull_o,
  output      logic [7:0]  pc_out_o,
  output      logic [7:0]  pc_oe_o,
  output      logic [7:0]  pc_pull_o,
  output      logic [7:0]  pd_out_o,
  output      logic [7:0]  pd_oe_o,
  output      logic [7:0]  pd_pull_o,
  // Peripheral side
  input  wire logic        timer0_compare_out_i,
  input  wire logic        timer1_compare_a_out_i,
  input  wire logic [7:0]  ext_addr_hi_i,
  input  wire logic        mem_rd_strobe_i,
  input  wire logic        mem_wr_strobe_i,
  input  wire logic        sck_out_i,
  input  wire logic        spi_master_out_i,
  input  wire logic        spi_slave_out_i,
  input  wire logic        usart_sync_clk_out_i,
  input  wire logic        aux_sync_clk_out_i,
  input  wire logic        usart_tx_data_i,
  output      logic        sck_in_o,
  output      logic        spi_master_in_o,
  output      logic        spi_slave_in_o,
  output      logic        spi_slave_active_o,
  output      logic        timer0_count_in_o,
  output      logic        timer1_count_in_o,
  output      logic        usart_sync_clk_in_o,
  output      logic        aux_sync_clk_in_o,
  output      logic        ext_irq_zero_in_o,
  output      logic        ext_irq_one_in_o
);

  // ==========================================================================
  // Registers
  logic [pao_pkg::CTL_W-1:0] ctl_r;
  logic [15:0]               pb_r;
  logic [15:0]               pc_r;
  logic [15:0]               pd_r;
  logic                      dp_wr_r;
  logic [2:0]                dp_idx_r;

  // ==========================================================================
  // Bus decode
  wire       acc      = hsel_i & hready_i & htrans_i[1];
  wire [2:0] acc_idx  = haddr_i[pao_pkg::ADDR_MSB:pao_pkg::ADDR_LSB];
  wire       do_wr    = dp_wr_r;
  wire       sel_ctl  = dp_idx_r == pao_pkg::ADDR_CTRL[4:2];
  wire       sel_pb   = dp_idx_r == pao_pkg::ADDR_PORTB[4:2];
  wire       sel_pc   = dp_idx_r == pao_pkg::ADDR_PORTC[4:2];
  wire       sel_pd   = dp_idx_r == pao_pkg::ADDR_PORTD[4:2];
  wire       rsel_ctl = acc_idx == pao_pkg::ADDR_CTRL[4:2];
  wire       rsel_pb  = acc_idx == pao_pkg::ADDR_PORTB[4:2];
  wire       rsel_pc  = acc_idx == pao_pkg::ADDR_PORTC[4:2];
  wire       rsel_pd  = acc_idx == pao_pkg::ADDR_PORTD[4:2];
  wire       rsel_st  = acc_idx == pao_pkg::ADDR_STATUS[4:2];
  wire       in_range = haddr_i[31:5] == 27'h0;

  // ==========================================================================
  // Control fields
  wire       ext_mem_enable    = ctl_r[pao_pkg::CTL_EXT_MEM];
  wire [2:0] high_addr_release =
    ctl_r[pao_pkg::CTL_REL_LSB +: pao_pkg::CTL_REL_W];
  wire       serial_port_on    = ctl_r[pao_pkg::CTL_SER_ON];
  wire       serial_is_master  = ctl_r[pao_pkg::CTL_SER_MASTER];
  wire       global_pullup_off = ctl_r[pao_pkg::CTL_PULL_OFF];
  wire       t0_en             = ctl_r[pao_pkg::CTL_T0_EN];
  wire       t1a_en            = ctl_r[pao_pkg::CTL_T1A_EN];
  wire       usart_sync        = ctl_r[pao_pkg::CTL_USART_SYNC];
  wire       tx_en             = ctl_r[pao_pkg::CTL_TX_EN];
  wire       irq0_en           = ctl_r[pao_pkg::CTL_IRQ0_EN];
  wire       irq1_en           = ctl_r[pao_pkg::CTL_IRQ1_EN];

  wire [7:0] pb_val = pb_r[pao_pkg::DATA_LSB +: 8];
  wire [7:0] pb_dir = pb_r[pao_pkg::DIR_LSB +: 8];
  wire [7:0] pc_val = pc_r[pao_pkg::DATA_LSB +: 8];
  wire [7:0] pc_dir = pc_r[pao_pkg::DIR_LSB +: 8];
  wire [7:0] pd_val = pd_r[pao_pkg::DATA_LSB +: 8];
  wire [7:0] pd_dir = pd_r[pao_pkg::DIR_LSB +: 8];

  // ==========================================================================
  // Port B overrides
  wire spi_slave = serial_port_on & ~serial_is_master;
  wire spi_mast  = serial_port_on & serial_is_master;
  logic [7:0] b_pullup_override_en, b_puov, b_direction_override_en, b_direction_override_val, b_pin_value_override_en, b_pin_value_override_val;
  // [RULE18] Slave forces SCK, MOSI, select to input
  // [RULE4] MISO input in master mode, slave drives it
  // [RULE5] MOSI master output, slave input
  assign b_pullup_override_en = {spi_slave, spi_mast, spi_slave, spi_slave, 4'h0};
  assign b_puov = pb_val & {8{~global_pullup_off}};
  assign b_direction_override_en = b_pullup_override_en;
  assign b_direction_override_val = 8'h00;
  // [RULE1] Compare drives only when direction is output
  // [RULE2] Waveform uses same override path
  assign b_pin_value_override_en = {spi_mast, spi_slave, spi_mast, 4'h0,
                   t0_en & pb_dir[pao_pkg::PB_T0]};
  assign b_pin_value_override_val = {sck_out_i, spi_slave_out_i, spi_master_out_i, 4'h0,
                   timer0_compare_out_i};
  // [RULE3] Comparator pins get no override, left to software

  // ==========================================================================
  // Port C overrides
  logic [7:0] c_own;
  // [RULE7] Per-bit release thresholds
  // [RULE8] Low pair freed together
  for (genvar i = 0; i < 8; i++) begin : g_c
    localparam logic [3:0] LIM = (i < 2) ? 4'h7 : 4'(8 - i);
    assign c_own[i] = ext_mem_enable & ({1'b0, high_addr_release} < LIM);
  end

  // ==========================================================================
  // Port D overrides
  wire xck_on = usart_sync;
  logic [7:0] d_pin_value_override_en, d_pin_value_override_val, d_direction_override_en;
  // [RULE9] Read strobe
  // [RULE10] Write strobe
  // [RULE11] Timer1 A only when output
  // [RULE12] D4 direction selects drive
  // [RULE13] Only in synchronous mode
  // [RULE14] Aux clock out when direction set
  // [RULE15] Transmitter forces output
  assign d_pin_value_override_en = {ext_mem_enable, ext_mem_enable,
                   t1a_en & pd_dir[pao_pkg::PD_T1A],
                   xck_on & pd_dir[pao_pkg::PD_XCK], 1'b0,
                   pd_dir[pao_pkg::PD_IRQ0], tx_en, 1'b0};
  assign d_pin_value_override_val = {mem_rd_strobe_i, mem_wr_strobe_i, timer1_compare_a_out_i,
                   usart_sync_clk_out_i, 1'b0, aux_sync_clk_out_i,
                   usart_tx_data_i, 1'b0};
  assign d_direction_override_en = {ext_mem_enable, ext_mem_enable, 4'h0, tx_en, 1'b0};

  // ==========================================================================
  // Pin banks
  logic [7:0] b_out, b_oe, b_pull, c_out, c_oe, c_pull, d_out, d_oe, d_pull;

  pao_bank #(.W(8)) u_pb (
    .val_i      (pb_val),
    .dir_i      (pb_dir),
    .pull_off_i (global_pullup_off),
    .pullup_override_en_i     (b_pullup_override_en),
    .puov_i     (b_puov),
    .direction_override_en_i     (b_direction_override_en),
    .direction_override_val_i     (b_direction_override_val),
    .pin_value_override_en_i     (b_pin_value_override_en),
    .pin_value_override_val_i     (b_pin_value_override_val),
    .out_o      (b_out),
    .oe_o       (b_oe),
    .pull_o     (b_pull)
  );

  // [RULE6] Address high byte on C
  pao_bank #(.W(8)) u_pc (
    .val_i      (pc_val),
    .dir_i      (pc_dir),
    .pull_off_i (global_pullup_off),
    .pullup_override_en_i     (c_own),
    .puov_i     (8'h00),
    .direction_override_en_i     (c_own),
    .direction_override_val_i     (8'hff),
    .pin_value_override_en_i     (c_own),
    .pin_value_override_val_i     (ext_addr_hi_i),
    .out_o      (c_out),
    .oe_o       (c_oe),
    .pull_o     (c_pull)
  );

  pao_bank #(.W(8)) u_pd (
    .val_i      (pd_val),
    .dir_i      (pd_dir),
    .pull_off_i (global_pullup_off),
    .pullup_override_en_i     (d_direction_override_en),
    .puov_i     (8'h00),
    .direction_override_en_i     (d_direction_override_en),
    .direction_override_val_i     (8'hff),
    .pin_value_override_en_i     (d_pin_value_override_en),
    .pin_value_override_val_i     (d_pin_value_override_val),
    .out_o      (d_out),
    .oe_o       (d_oe),
    .pull_o     (d_pull)
  );

  // ==========================================================================
  // Read data
  wire [31:0] st_word = {8'h00, pd_in_i, pc_in_i, pb_in_i};
  wire [31:0] rd_mux  =
    !in_range ? 32'h0000_0000 :
    rsel_ctl  ? {19'h0, ctl_r} :
    rsel_pb   ? {16'h0, pb_r} :
    rsel_pc   ? {16'h0, pc_r} :
    rsel_pd   ? {16'h0, pd_r} :
    rsel_st   ? st_word : 32'h0000_0000;

  // ==========================================================================
  // Clocked state
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dp_wr_r  <= 1'b0;
      dp_idx_r <= 3'h7;
      hrdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      dp_wr_r  <= acc & hwrite_i & in_range;
      dp_idx_r <= acc_idx;
      if (acc & ~hwrite_i) hrdata_o <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctl_r <= pao_pkg::CTL_RST;
      pb_r  <= {pao_pkg::PORT_RST, pao_pkg::PORT_RST};
      pc_r  <= {pao_pkg::PORT_RST, pao_pkg::PORT_RST};
      pd_r  <= {pao_pkg::PORT_RST, pao_pkg::PORT_RST};
    end else if (clk_en_i & do_wr) begin
      if (sel_ctl) ctl_r <= hwdata_i[pao_pkg::CTL_W-1:0];
      if (sel_pb)  pb_r  <= hwdata_i[15:0];
      if (sel_pc)  pc_r  <= hwdata_i[15:0];
      if (sel_pd)  pd_r  <= hwdata_i[15:0];
    end
  end

  // Zero wait, always OKAY: no transfer here can fail
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (clk_en_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ==========================================================================
  // Pin outputs, one flop behind the overrides
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pb_out_o  <= 8'h00;
      pb_oe_o   <= 8'h00;
      pb_pull_o <= 8'h00;
    end else if (clk_en_i) begin
      pb_out_o  <= b_out;
      pb_oe_o   <= b_oe;
      pb_pull_o <= b_pull;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pc_out_o  <= 8'h00;
      pc_oe_o   <= 8'h00;
      pc_pull_o <= 8'h00;
    end else if (clk_en_i) begin
      pc_out_o  <= c_out;
      pc_oe_o   <= c_oe;
      pc_pull_o <= c_pull;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pd_out_o  <= 8'h00;
      pd_oe_o   <= 8'h00;
      pd_pull_o <= 8'h00;
    end else if (clk_en_i) begin
      pd_out_o  <= d_out;
      pd_oe_o   <= d_oe;
      pd_pull_o <= d_pull;
    end
  end

  // ==========================================================================
  // Pin inputs towards the peripherals
  // Serial inputs pass in both modes; the unused one is ignored
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sck_in_o           <= 1'b0;
      spi_master_in_o    <= 1'b0;
      spi_slave_in_o     <= 1'b0;
      spi_slave_active_o <= 1'b0;
    end else if (clk_en_i) begin
      sck_in_o           <= pb_in_i[pao_pkg::PB_SCK];
      spi_master_in_o    <= pb_in_i[pao_pkg::PB_MISO];
      spi_slave_in_o     <= pb_in_i[pao_pkg::PB_MOSI];
      // [RULE17] Slave live only while select low
      spi_slave_active_o <= spi_slave & ~pb_in_i[pao_pkg::PB_SEL];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      timer0_count_in_o   <= 1'b0;
      timer1_count_in_o   <= 1'b0;
      usart_sync_clk_in_o <= 1'b0;
      aux_sync_clk_in_o   <= 1'b0;
    end else if (clk_en_i) begin
      timer0_count_in_o   <= pb_in_i[pao_pkg::PB_T0];
      timer1_count_in_o   <= pb_in_i[pao_pkg::PB_T1];
      usart_sync_clk_in_o <= xck_on & pd_in_i[pao_pkg::PD_XCK];
      aux_sync_clk_in_o   <= pd_in_i[pao_pkg::PD_IRQ0];
    end
  end

  // [RULE16] Interrupt inputs stay readable
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ext_irq_zero_in_o <= 1'b0;
      ext_irq_one_in_o  <= 1'b0;
    end else if (clk_en_i) begin
      ext_irq_zero_in_o <= irq0_en & pd_in_i[pao_pkg::PD_IRQ0];
      ext_irq_one_in_o  <= irq1_en & pd_in_i[pao_pkg::PD_IRQ1];
    end
  end

endmodule

`default_nettype wire

// File: bench/pao_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Port-level checks of the override block
module pao_top_asserts (
  // Clock and control
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       clk_en_i,
  // Bus answer
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  // Pins
  input wire logic [7:0] pb_in_i,
  input wire logic [7:0] pd_in_i,
  input wire logic [7:0] pb_oe_o,
  input wire logic [7:0] pc_oe_o,
  input wire logic [7:0] pd_oe_o,
  input wire logic [7:0] pd_out_o,
  // Peripheral side
  input wire logic       sck_in_o,
  input wire logic       spi_master_in_o,
  input wire logic       spi_slave_in_o,
  input wire logic       spi_slave_active_o,
  input wire logic       usart_sync_clk_in_o,
  input wire logic       aux_sync_clk_in_o,
  input wire logic       ext_irq_zero_in_o,
  input wire logic       ext_irq_one_in_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Only a live edge outside reset moves the output flops
  sequence s_fresh;
    $past(clk_en_i) && !$past(sys_rst_i);
  endsequence

  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  a_reset_quiet: assert property (
    $fell(sys_rst_i) |-> (pb_oe_o | pc_oe_o | pd_oe_o) == 8'h00)
    else $error("pin driven straight after reset");
  a_freeze_hold: assert property (
    !clk_en_i |=> $stable(pd_out_o) && $stable(pb_oe_o))
    else $error("pins moved while frozen");
  a_sck_input: assert property (
    s_fresh |-> sck_in_o == $past(pb_in_i[7]))
    else $error("clock input not from its pin");
  a_miso_path: assert property (
    s_fresh |-> spi_master_in_o == $past(pb_in_i[6]))
    else $error("master input not from its pin");
  a_mosi_path: assert property (
    s_fresh |-> spi_slave_in_o == $past(pb_in_i[5]))
    else $error("slave input not from its pin");
  a_select_low: assert property (
    s_fresh ##0 spi_slave_active_o |-> !$past(pb_in_i[4]))
    else $error("slave active with select high");
  a_irq_zero: assert property (
    s_fresh ##0 ext_irq_zero_in_o |-> $past(pd_in_i[2]))
    else $error("interrupt zero without pin high");
  a_irq_one: assert property (
    s_fresh ##0 ext_irq_one_in_o |-> $past(pd_in_i[3]))
    else $error("interrupt one without pin high");
  a_aux_clock: assert property (
    s_fresh |-> aux_sync_clk_in_o == $past(pd_in_i[2]))
    else $error("aux clock input not from its pin");
  a_usart_clock: assert property (
    s_fresh ##0 usart_sync_clk_in_o |-> $past(pd_in_i[4]))
    else $error("usart clock input without pin high");
endmodule

bind pao_top pao_top_asserts i_chk (.sys_clk_i, .sys_rst_i, .clk_en_i,
  .hreadyout_o, .hresp_o, .pb_in_i, .pd_in_i, .pb_oe_o, .pc_oe_o,
  .pd_oe_o, .pd_out_o, .sck_in_o, .spi_master_in_o, .spi_slave_in_o,
  .spi_slave_active_o, .usart_sync_clk_in_o, .aux_sync_clk_in_o,
  .ext_irq_zero_in_o, .ext_irq_one_in_o);

`default_nettype wire

// File: bench/pao_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Board pins: design drive wins, then board drive, then pull-up
module pao_pin_model (
  input  wire logic        sys_clk_i,
  input  wire logic [23:0] out_i,
  input  wire logic [23:0] oe_i,
  input  wire logic [23:0] pull_i,
  input  wire logic [23:0] ext_i,
  input  wire logic [23:0] ext_en_i,
  output wire logic [23:0] lvl_o
);
  // Floating pins wander so a stale level never passes
  logic float_r = 1'b0;
  always_ff @(posedge sys_clk_i) begin
    float_r <= ~float_r;
  end
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
               | (~oe_i & ~ext_en_i & (pull_i | {24{float_r}}));
endmodule

`default_nettype wire

// File: bench/port_alternate_function_override_tb.sv
`timescale 1ns/1ps
`default_nettype none

module port_alternate_function_override_tb;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en_i  = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  wire  [31:0] hrdata;
  wire         hrdy, hresp;
  wire  [7:0]  pb_out, pb_oe, pb_pull, pc_out, pc_oe, pc_pull;
  wire  [7:0]  pd_out, pd_oe, pd_pull;
  wire  [9:0]  po;
  wire  [23:0] lvl;
  logic [9:0]  pv = 10'h000;
  logic [7:0]  addr_hi = 8'ha5;
  logic [7:0]  m;
  logic [23:0] ext = 24'h3c5a96, ext_en = 24'hffffff;
  int          n_mismatch = 0, checks = 0, cyc = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  pao_top i_dut (.sys_clk_i, .sys_rst_i, .clk_en_i, .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .pb_in_i(lvl[7:0]), .pc_in_i(lvl[15:8]), .pd_in_i(lvl[23:16]),
    .pb_out_o(pb_out), .pb_oe_o(pb_oe), .pb_pull_o(pb_pull),
    .pc_out_o(pc_out), .pc_oe_o(pc_oe), .pc_pull_o(pc_pull),
    .pd_out_o(pd_out), .pd_oe_o(pd_oe), .pd_pull_o(pd_pull),
    .timer0_compare_out_i(pv[0]), .timer1_compare_a_out_i(pv[1]),
    .ext_addr_hi_i(addr_hi), .mem_rd_strobe_i(pv[2]),
    .mem_wr_strobe_i(pv[3]), .sck_out_i(pv[4]),
    .spi_master_out_i(pv[5]), .spi_slave_out_i(pv[6]),
    .usart_sync_clk_out_i(pv[7]), .aux_sync_clk_out_i(pv[8]),
    .usart_tx_data_i(pv[9]), .sck_in_o(po[0]),
    .spi_master_in_o(po[1]), .spi_slave_in_o(po[2]),
    .spi_slave_active_o(po[3]), .timer0_count_in_o(po[4]),
    .timer1_count_in_o(po[5]), .usart_sync_clk_in_o(po[6]),
    .aux_sync_clk_in_o(po[7]), .ext_irq_zero_in_o(po[8]),
    .ext_irq_one_in_o(po[9]));

  pao_pin_model i_pins (.sys_clk_i, .out_i({pd_out, pc_out, pb_out}),
    .oe_i({pd_oe, pc_oe, pb_oe}), .pull_i({pd_pull, pc_pull, pb_pull}),
    .ext_i(ext), .ext_en_i(ext_en), .lvl_o(lvl));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // One single word transfer; waits on hready in both phases
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= pao_pkg::HSIZE_WORD;
    htrans <= pao_pkg::HTRANS_NONSEQ;
    do @(posedge sys_clk_i); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic cfg(input logic [12:0] c, input logic [15:0] b,
                     input logic [15:0] cc, input logic [15:0] d);
    bus(pao_pkg::ADDR_CTRL, 1'b1, {19'h0, c});
    bus(pao_pkg::ADDR_PORTB, 1'b1, {16'h0, b});
    bus(pao_pkg::ADDR_PORTC, 1'b1, {16'h0, cc});
    bus(pao_pkg::ADDR_PORTD, 1'b1, {16'h0, d});
    settle();
  endtask

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, read-only status, unmapped place
    bus(32'h14, 1'b1, 32'hffffffff);
    bus(pao_pkg::ADDR_STATUS, 1'b1, 32'h0);
    for (int a = 0; a < 24; a += 4) begin
      bus(a, 1'b0, 32'h0);
      chk(q, (a == 16) ? {8'h00, ext} : 32'h0);
    end
    chk({pb_oe, pc_oe, pd_oe}, 24'h0);
    chk(po[5:4], 2'b10);
    $display("test reset done");
    cfg(13'h0000, 16'hf153, 16'h0f3c, 16'h0f3c);
    chk({pb_oe, pb_out, pb_pull}, 24'hf15302);
    chk({pc_pull, pd_pull}, 16'h3030);
    cfg(13'h0040, 16'hf153, 16'h0f3c, 16'h0f3c);
    chk({pb_pull, pc_pull, pd_pull}, 24'h0);
    $display("test plain port done");
    for (int i = 0; i < 4; i++) begin
      pv[1:0] <= {2{i[0]}};
      cfg(13'h0180, {7'h0, i[1], 8'h0}, 16'h0, {2'h0, i[1], 13'h0});
      chk({pb_oe[0], pb_out[0] & pb_oe[0]}, {i[1], i[1] & i[0]});
      chk({pd_oe[5], pd_out[5] & pd_oe[5]}, {i[1], i[1] & i[0]});
    end
    $display("test compare outputs done");
    pv[3:2] <= 2'b01;
    for (int r = 0; r < 8; r++) begin
      cfg({9'h0, r[2:0], 1'b1}, 16'h0, 16'h0, 16'h0);
      m = {r < 1, r < 2, r < 3, r < 4, r < 5, r < 6, r < 7, r < 7};
      chk({pc_oe, pc_out, pc_pull}, {m, 8'ha5 & m, 8'h00});
      chk(pc_oe[1:0], {r < 7, r < 7});
      chk(pc_out | ~pc_oe, 8'ha5 | ~m);
      chk({pd_oe[7:6], pd_out[7:6]}, 4'b1110);
    end
    $display("test external memory done");
    pv[9:7] <= 3'b111;
    cfg(13'h1e00, 16'h0, 16'h0, 16'h1400);
    chk({pd_oe, pd_out & 8'h16}, 16'h1616);
    cfg(13'h1e00, 16'h0, 16'h0, 16'h0000);
    chk({pd_oe, po[9:6]}, {8'h02, 4'hf});
    cfg(13'h0400, 16'h0, 16'h0, 16'h0000);
    chk({pd_oe, po[9:6]}, {8'h02, 4'h2});
    $display("test port d done");
    pv[6:4] <= 3'b011;
    cfg(13'h0030, 16'he000, 16'h0, 16'h0);
    chk({pb_oe[7:5], pb_out[7], pb_out[5], po[1]}, 6'b101110);
    pv[6] <= 1'b1;
    cfg(13'h0010, 16'he000, 16'h0, 16'h0);
    chk({pb_oe[7:5], pb_out[6], po[0], po[3:2]}, 7'b0101100);
    // External master selects and drives data in
    ext[5:4] <= 2'b10;
    settle();
    chk(po[3:2], 2'b11);
    $display("test serial done");
    clk_en_i <= 1'b0;
    ext[4] <= 1'b1;
    settle();
    chk(po[3], 1'b1);
    clk_en_i <= 1'b1;
    settle();
    chk(po[3], 1'b0);
    $display("test freeze done");
    end_of_test();
  end
endmodule

`default_nettype wire
